// ==== rtl/ddr3_controller_end.sv ====
`timescale 1ns/100ps
// Purpose: Controller end: spaces commands, drives write bursts, takes reads
// Assumes: User holds a request until ready; one write burst in flight
// Notes: Ready is combinational from timer state and the request
module ddr3_controller_end import ddr3_timing_pkg::*; (
	input logic mclk,
	input logic rst,
	ddr3_link_if.controller link,
	input logic req_valid,
	input cmd_type req_cmd,
	input logic [BANK_W-1:0] req_bank,
	input logic [ADDR_W-1:0] req_addr,
	input logic [BURST_CYCLES*DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic loop_locked
);
	logic [BANKS-1:0][TIMER_W-1:0] rtp, next_rtp, wrec, next_wrec, dal, next_dal;
	logic [FAW_SLOTS-1:0][TIMER_W-1:0] faw, next_faw;
	logic [TIMER_W-1:0] wtr, next_wtr, mrd, next_mrd, mod, next_mod;
	logic [TIMER_W-1:0] ccd, next_ccd, rrd, next_rrd, mprr, next_mprr;
	logic [TIMER_W-1:0] dll, next_dll, wr_left, next_wr_left;
	logic [3:0] write_recovery, next_write_recovery;
	logic next_loop_locked;
	logic [2:0] faw_busy;
	logic issue;
	cmd_type next_cmd;
	logic [BANK_W-1:0] next_bank;
	logic [ADDR_W-1:0] next_addr;
	logic [BURST_CYCLES*DATA_W-1:0] wbuf, next_wbuf;
	logic [HIST_DEPTH-1:0] wr_hist, next_wr_hist;
	logic [DATA_W-1:0] next_dq;
	logic next_dq_oe_n, next_dqs, next_dqs_oe_n, next_rd_valid;
	logic [DATA_W-1:0] next_rd_data;

	// ----------------------------------------
	// Command gate
	// ----------------------------------------
	// Stalling here is cheaper than letting the memory see a bad spacing
	always_comb begin
		faw_busy = '0;
		for (int s = 0; s < FAW_SLOTS; s++) begin
			if (faw[s] != '0) begin
				faw_busy = faw_busy + 3'h1;
			end
		end
		req_ready = (mprr == '0);
		if (req_cmd != cmd_mode_set && mod != '0) begin
			req_ready = 1'b0;
		end
		case (req_cmd)
			cmd_activate: begin
				if (rrd != '0) begin
					req_ready = 1'b0;
				end
				if (faw_busy == 3'(FAW_SLOTS)) begin
					req_ready = 1'b0;
				end
				if (dal[req_bank] != '0) begin
					req_ready = 1'b0;
				end
			end
			cmd_read: begin
				if (ccd != '0 || wtr != '0 || dll != '0) begin
					req_ready = 1'b0;
				end
			end
			cmd_write: begin
				// Only one burst buffered, so a write waits for the last to leave
				if (ccd != '0 || dll != '0 || wr_left != '0) begin
					req_ready = 1'b0;
				end
			end
			cmd_precharge: begin
				if (rtp[req_bank] != '0) begin
					req_ready = 1'b0;
				end
				if (wrec[req_bank] != '0) begin
					req_ready = 1'b0;
				end
			end
			cmd_mode_set: begin
				if (mrd != '0) begin
					req_ready = 1'b0;
				end
			end
			cmd_pattern: begin
				req_ready = req_ready;
			end
			default: begin
				req_ready = req_ready;
			end
		endcase
	end

	assign issue = req_valid && req_ready;

	// ----------------------------------------
	// Spacing timers
	// ----------------------------------------
	always_comb begin
		logic placed;
		placed = 1'b0;
		for (int b = 0; b < BANKS; b++) begin
			next_rtp[b] = timer_step(rtp[b]);
			next_wrec[b] = timer_step(wrec[b]);
			next_dal[b] = timer_step(dal[b]);
		end
		for (int s = 0; s < FAW_SLOTS; s++) begin
			next_faw[s] = timer_step(faw[s]);
		end
		next_wtr = timer_step(wtr);
		next_mrd = timer_step(mrd);
		next_mod = timer_step(mod);
		next_ccd = timer_step(ccd);
		next_rrd = timer_step(rrd);
		next_mprr = timer_step(mprr);
		next_dll = timer_step(dll);
		next_wr_left = timer_step(wr_left);
		next_write_recovery = write_recovery;
		if (issue) begin
			case (req_cmd)
				cmd_activate: begin
					next_rrd = RRD_LOAD;
					for (int s = 0; s < FAW_SLOTS; s++) begin
						if (!placed && faw[s] == '0) begin
							next_faw[s] = FAW_LOAD;
							placed = 1'b1;
						end
					end
				end
				cmd_read: begin
					next_rtp[req_bank] = RTP_LOAD;
					next_ccd = CCD_LOAD;
				end
				cmd_write: begin
					next_ccd = CCD_LOAD;
					next_wtr = WTR_LOAD;
					next_wrec[req_bank] = WREC_LOAD;
					next_wr_left = WR_BUSY_LOAD;
					if (req_addr[AUTO_PRECHARGE_BIT]) begin
						next_dal[req_bank] = autoprecharge_write_total(write_recovery);
					end
				end
				cmd_mode_set: begin
					next_mrd = MRD_LOAD;
					next_mod = MOD_LOAD;
					next_write_recovery = req_addr[RECOVERY_LSB +: 4];
					if (req_addr[LOOP_RESET_BIT]) begin
						next_dll = DLL_LOAD;
					end
				end
				cmd_pattern: begin
					next_mprr = MPRR_LOAD;
				end
				default: begin
					placed = 1'b0;
				end
			endcase
		end
		next_loop_locked = (next_dll == '0);
	end

	// Loop lock is assumed lost at reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rtp <= '0;
			wrec <= '0;
			dal <= '0;
			faw <= '0;
			wtr <= '0;
			mrd <= '0;
			mod <= '0;
			ccd <= '0;
			rrd <= '0;
			mprr <= '0;
			dll <= DLL_LOAD;
			wr_left <= '0;
			write_recovery <= WRITE_RECOVERY_RESET;
			loop_locked <= 1'b0;
		end else begin
			rtp <= next_rtp;
			wrec <= next_wrec;
			dal <= next_dal;
			faw <= next_faw;
			wtr <= next_wtr;
			mrd <= next_mrd;
			mod <= next_mod;
			ccd <= next_ccd;
			rrd <= next_rrd;
			mprr <= next_mprr;
			dll <= next_dll;
			wr_left <= next_wr_left;
			write_recovery <= next_write_recovery;
			loop_locked <= next_loop_locked;
		end
	end

	// ----------------------------------------
	// Link drive and read capture
	// ----------------------------------------
	// Tap k of the next history is output in cycle k after the link command
	always_comb begin
		next_cmd = issue ? req_cmd : cmd_nop;
		next_bank = issue ? req_bank : link.bank;
		next_addr = issue ? req_addr : link.addr;
		next_wbuf = (issue && req_cmd == cmd_write) ? req_wdata : wbuf;
		next_wr_hist = {wr_hist[HIST_DEPTH-2:0], issue && req_cmd == cmd_write};
		next_dqs_oe_n = 1'b1;
		next_dqs = 1'b0;
		next_dq_oe_n = 1'b1;
		next_dq = '0;
		for (int k = 0; k < HIST_DEPTH; k++) begin
			if (next_wr_hist[k] && k >= WRITE_LATENCY - STROBE_PREAMBLE_CYCLES && k < WRITE_LATENCY) begin
				next_dqs_oe_n = 1'b0;
			end
			if (next_wr_hist[k] && k >= WRITE_LATENCY && k < WRITE_LATENCY + BURST_CYCLES) begin
				// Low half of the last cycle is the postamble before release
				next_dqs_oe_n = 1'b0;
				next_dqs = 1'b1;
				next_dq_oe_n = 1'b0;
				next_dq = next_wbuf[(k - WRITE_LATENCY)*DATA_W +: DATA_W];
			end
		end
		// Source-synchronous: the memory's own strobe marks each read word
		next_rd_valid = !link.dqs_dev_oe_n && link.dqs_dev;
		next_rd_data = next_rd_valid ? link.dq_dev : rd_data;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			link.cmd <= cmd_nop;
			link.bank <= '0;
			link.addr <= '0;
			wbuf <= '0;
			wr_hist <= '0;
			link.dqs_ctl_oe_n <= 1'b1;
			link.dqs_ctl <= 1'b0;
			link.dq_ctl_oe_n <= 1'b1;
			link.dq_ctl <= '0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			link.cmd <= next_cmd;
			link.bank <= next_bank;
			link.addr <= next_addr;
			wbuf <= next_wbuf;
			wr_hist <= next_wr_hist;
			link.dqs_ctl_oe_n <= next_dqs_oe_n;
			link.dqs_ctl <= next_dqs;
			link.dq_ctl_oe_n <= next_dq_oe_n;
			link.dq_ctl <= next_dq;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end
endmodule

// ==== rtl/ddr3_timing_pkg.sv ====
// Purpose: Shared constants, types and helpers for both ends of the link
// Assumes: One 20 MHz clock; one link cycle carries two 16-bit beats
// Notes: Times are held in ps and turned into cycle counts here
//
// What this block does
// - Read to same-bank precharge waits four cycles.
// - Write data end to read waits.
// - Mode sets spaced four cycles apart.
// - Mode set update delay before other commands.
// - Column commands spaced four cycles apart.
// - Auto-precharge write blocks bank activate.
// - Multipurpose register change needs recovery.
// - Activates spaced by activate delay.
// - At most four activates per window.
// - Read strobe preamble before first edge.
// - Read strobe postamble before release.
// - Controller write strobe preamble and postamble.
// - Read strobe driven at latency minus one.
// - Read strobe released at latency plus four.
package ddr3_timing_pkg;
	// ----------------------------------------
	// Link shape and command fields
	// ----------------------------------------
	localparam int BANKS = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 32;
	localparam int BURST_LENGTH = 8;
	localparam int BURST_CYCLES = BURST_LENGTH / 2;
	localparam int BEAT_W = 2;
	localparam int HIST_DEPTH = 20;
	localparam int TIMER_W = 10;
	localparam int FAW_SLOTS = 4;
	localparam int MEM_WORDS = BANKS * BURST_CYCLES;
	localparam int LATENCY_LSB = 0;
	localparam int RECOVERY_LSB = 4;
	localparam int LOOP_RESET_BIT = 8;
	localparam int PATTERN_ENABLE_BIT = 2;
	localparam int AUTO_PRECHARGE_BIT = 10;
	localparam logic [3:0] READ_LATENCY_RESET = 4'h6;
	localparam logic [3:0] WRITE_RECOVERY_RESET = 4'h5;
	localparam int WRITE_LATENCY = 5;
	localparam logic [DATA_W-1:0] MULTI_PURPOSE_REGISTER_PATTERN = 32'h00ff_00ff;

	typedef enum logic [2:0] {
		cmd_nop, cmd_activate, cmd_read, cmd_write, cmd_precharge, cmd_mode_set, cmd_pattern
	} cmd_type;

	// ----------------------------------------
	// Timing, printed figures then cycle counts
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 50000;

	// Least times round up to whole cycles
	function automatic int cycles_up(input int ps);
		return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	endfunction

	function automatic int max_of(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int READ_TO_PRECHARGE_DELAY_PS = 7500;
	localparam int READ_TO_PRECHARGE_DELAY_CYCLES = max_of(4, cycles_up(READ_TO_PRECHARGE_DELAY_PS));
	localparam int WRITE_TO_READ_TURNAROUND_PS = 7500;
	localparam int WRITE_TO_READ_TURNAROUND_CYCLES = max_of(4, cycles_up(WRITE_TO_READ_TURNAROUND_PS));
	localparam int MODE_SET_CYCLE_TIME_CYCLES = 4;
	localparam int MODE_SET_UPDATE_DELAY_PS = 15000;
	localparam int MODE_SET_UPDATE_DELAY_CYCLES = max_of(12, cycles_up(MODE_SET_UPDATE_DELAY_PS));
	localparam int COLUMN_TO_COLUMN_DELAY_CYCLES = 4;
	localparam int MULTIPURPOSE_REG_RECOVERY_CYCLES = 1;
	localparam int ACTIVATE_TO_ACTIVATE_DELAY_PS = 6000;
	localparam int ACTIVATE_TO_ACTIVATE_DELAY_CYCLES = max_of(4, cycles_up(ACTIVATE_TO_ACTIVATE_DELAY_PS));
	localparam int FOUR_ACTIVATE_WINDOW_PS = 35000;
	localparam int FOUR_ACTIVATE_WINDOW_CYCLES = cycles_up(FOUR_ACTIVATE_WINDOW_PS);
	localparam int LOOP_LOCK_TIME_CYCLES = 512;
	localparam int WRITE_RECOVERY_TIME_PS = 15000;
	localparam int WRITE_RECOVERY_TIME_CYCLES = cycles_up(WRITE_RECOVERY_TIME_PS);
	localparam int PRECHARGE_PERIOD_PS = 15000;
	localparam int PRECHARGE_PERIOD_CYCLES = cycles_up(PRECHARGE_PERIOD_PS);
	localparam int STROBE_PREAMBLE_TENTHS = 9;
	localparam int STROBE_PREAMBLE_CYCLES = (STROBE_PREAMBLE_TENTHS + 9) / 10;

	// Timer loads: a timer loaded with N-1 lets the next command go N cycles later
	localparam logic [TIMER_W-1:0] RTP_LOAD = TIMER_W'(READ_TO_PRECHARGE_DELAY_CYCLES - 1);
	localparam logic [TIMER_W-1:0] WTR_LOAD =
		TIMER_W'(WRITE_LATENCY + BURST_CYCLES + WRITE_TO_READ_TURNAROUND_CYCLES - 1);
	localparam logic [TIMER_W-1:0] WREC_LOAD =
		TIMER_W'(WRITE_LATENCY + BURST_CYCLES + WRITE_RECOVERY_TIME_CYCLES - 1);
	localparam logic [TIMER_W-1:0] MRD_LOAD = TIMER_W'(MODE_SET_CYCLE_TIME_CYCLES - 1);
	localparam logic [TIMER_W-1:0] MOD_LOAD = TIMER_W'(MODE_SET_UPDATE_DELAY_CYCLES - 1);
	localparam logic [TIMER_W-1:0] CCD_LOAD = TIMER_W'(COLUMN_TO_COLUMN_DELAY_CYCLES - 1);
	localparam logic [TIMER_W-1:0] MPRR_LOAD = TIMER_W'(MULTIPURPOSE_REG_RECOVERY_CYCLES - 1);
	localparam logic [TIMER_W-1:0] RRD_LOAD = TIMER_W'(ACTIVATE_TO_ACTIVATE_DELAY_CYCLES - 1);
	localparam logic [TIMER_W-1:0] FAW_LOAD = TIMER_W'(FOUR_ACTIVATE_WINDOW_CYCLES - 1);
	localparam logic [TIMER_W-1:0] DLL_LOAD = TIMER_W'(LOOP_LOCK_TIME_CYCLES - 1);
	localparam logic [TIMER_W-1:0] WR_BUSY_LOAD = TIMER_W'(WRITE_LATENCY + BURST_CYCLES);

	function automatic logic [TIMER_W-1:0] timer_step(input logic [TIMER_W-1:0] t);
		return (t == '0) ? t : t - 1'b1;
	endfunction

	// Bank lockout after an auto-precharge write, counted from the command
	function automatic logic [TIMER_W-1:0] autoprecharge_write_total(input logic [3:0] wr);
		return TIMER_W'(WRITE_LATENCY + BURST_CYCLES + int'(wr) + PRECHARGE_PERIOD_CYCLES - 1);
	endfunction
endpackage

// ==== rtl/ddr3_link_if.sv ====
`timescale 1ns/100ps
// Purpose: Command, data and strobe wires between the two ends
// Assumes: Each two-way pin is split into controller and device copies, each with its own enable
// Notes: Strobe complement is left to the pads
interface ddr3_link_if;
	import ddr3_timing_pkg::*;
	cmd_type cmd;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq_ctl;
	logic dq_ctl_oe_n;
	logic dqs_ctl;
	logic dqs_ctl_oe_n;
	logic [DATA_W-1:0] dq_dev;
	logic dq_dev_oe_n;
	logic dqs_dev;
	logic dqs_dev_oe_n;

	modport controller (
		output cmd, bank, addr, dq_ctl, dq_ctl_oe_n, dqs_ctl, dqs_ctl_oe_n,
		input dq_dev, dq_dev_oe_n, dqs_dev, dqs_dev_oe_n
	);
	modport device (
		input cmd, bank, addr, dq_ctl, dq_ctl_oe_n, dqs_ctl, dqs_ctl_oe_n,
		output dq_dev, dq_dev_oe_n, dqs_dev, dqs_dev_oe_n
	);
endinterface

// ==== rtl/ddr3_device_end.sv ====
`timescale 1ns/100ps
// Purpose: Memory end: mode settings, read strobe sequencing, write capture
// Assumes: Controller keeps command spacing; read latency set to 2 or more
// Notes: Small array holds one burst per bank
module ddr3_device_end import ddr3_timing_pkg::*; (
	input logic mclk,
	input logic rst,
	ddr3_link_if.device link,
	output logic [BANKS-1:0] bank_ready,
	output logic pattern_mode,
	output logic [3:0] read_latency
);
	logic [3:0] write_recovery, next_write_recovery, next_read_latency;
	logic next_pattern_mode;
	logic [BANKS-1:0][TIMER_W-1:0] dal, next_dal;
	logic [HIST_DEPTH-1:0] rd_hist, next_rd_hist, wr_hist, next_wr_hist;
	logic [HIST_DEPTH-1:0][BANK_W-1:0] rd_bank, next_rd_bank, wr_bank, next_wr_bank;
	logic [DATA_W-1:0] next_dq;
	logic next_dq_oe_n, next_dqs, next_dqs_oe_n;
	logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
	logic mem_we;
	logic [BANK_W+BEAT_W-1:0] mem_idx;

	// ----------------------------------------
	// Mode settings and bank lockout
	// ----------------------------------------
	always_comb begin
		next_read_latency = read_latency;
		next_write_recovery = write_recovery;
		next_pattern_mode = pattern_mode;
		if (link.cmd == cmd_mode_set) begin
			next_read_latency = link.addr[LATENCY_LSB +: 4];
			next_write_recovery = link.addr[RECOVERY_LSB +: 4];
		end
		if (link.cmd == cmd_pattern) begin
			next_pattern_mode = link.addr[PATTERN_ENABLE_BIT];
		end
		for (int b = 0; b < BANKS; b++) begin
			next_dal[b] = timer_step(dal[b]);
			if (link.cmd == cmd_write && link.bank == BANK_W'(b) && link.addr[AUTO_PRECHARGE_BIT]) begin
				next_dal[b] = autoprecharge_write_total(write_recovery);
			end
			bank_ready[b] = (dal[b] == '0);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			read_latency <= READ_LATENCY_RESET;
			write_recovery <= WRITE_RECOVERY_RESET;
			pattern_mode <= 1'b0;
			dal <= '0;
		end else begin
			read_latency <= next_read_latency;
			write_recovery <= next_write_recovery;
			pattern_mode <= next_pattern_mode;
			dal <= next_dal;
		end
	end

	// ----------------------------------------
	// Read strobe and data drive
	// ----------------------------------------
	// Tap k of the next history is output in cycle k+1 after the command.
	// Data pass runs after preamble pass so an older burst's tail wins.
	always_comb begin
		int lat;
		int rel;
		lat = int'(read_latency);
		rel = 0;
		next_rd_hist = {rd_hist[HIST_DEPTH-2:0], link.cmd == cmd_read};
		next_rd_bank = {rd_bank[HIST_DEPTH-2:0], link.bank};
		next_dqs_oe_n = 1'b1;
		next_dqs = 1'b0;
		next_dq_oe_n = 1'b1;
		next_dq = '0;
		for (int k = 0; k < HIST_DEPTH; k++) begin
			rel = k + 1;
			if (next_rd_hist[k] && rel >= lat - STROBE_PREAMBLE_CYCLES && rel < lat) begin
				next_dqs_oe_n = 1'b0;
				next_dqs = 1'b0;
			end
		end
		for (int k = 0; k < HIST_DEPTH; k++) begin
			rel = k + 1;
			if (next_rd_hist[k] && rel >= lat && rel < lat + BURST_CYCLES) begin
				// High half then low half; the low half is the postamble
				next_dqs_oe_n = 1'b0;
				next_dqs = 1'b1;
				next_dq_oe_n = 1'b0;
				next_dq = pattern_mode ? MULTI_PURPOSE_REGISTER_PATTERN :
					mem[{next_rd_bank[k], BEAT_W'(rel - lat)}];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_hist <= '0;
			rd_bank <= '0;
			link.dqs_dev_oe_n <= 1'b1;
			link.dqs_dev <= 1'b0;
			link.dq_dev_oe_n <= 1'b1;
			link.dq_dev <= '0;
		end else begin
			rd_hist <= next_rd_hist;
			rd_bank <= next_rd_bank;
			link.dqs_dev_oe_n <= next_dqs_oe_n;
			link.dqs_dev <= next_dqs;
			link.dq_dev_oe_n <= next_dq_oe_n;
			link.dq_dev <= next_dq;
		end
	end

	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	// Beats are only taken while the controller's strobe is driven high
	always_comb begin
		next_wr_hist = {wr_hist[HIST_DEPTH-2:0], link.cmd == cmd_write};
		next_wr_bank = {wr_bank[HIST_DEPTH-2:0], link.bank};
		mem_we = 1'b0;
		mem_idx = '0;
		for (int k = 0; k < BURST_CYCLES; k++) begin
			if (wr_hist[WRITE_LATENCY-1+k] && !link.dqs_ctl_oe_n && link.dqs_ctl) begin
				mem_we = 1'b1;
				mem_idx = {wr_bank[WRITE_LATENCY-1+k], BEAT_W'(k)};
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_hist <= '0;
			wr_bank <= '0;
		end else begin
			wr_hist <= next_wr_hist;
			wr_bank <= next_wr_bank;
		end
	end

	// Array has no reset; contents are undefined until written
	always_ff @(posedge mclk) begin
		if (mem_we) begin
			mem[mem_idx] <= link.dq_ctl;
		end
	end
endmodule

// ==== verif/ddr3_link_asserts.sv ====
`timescale 1ns/100ps
// Purpose: Concurrent checks on the link between controller and device ends
// Assumes: Read latency stays at 2 or more; no read in flight across a mode set
// Notes: Read windows come from a shift history of read commands
module ddr3_link_asserts import ddr3_timing_pkg::*; (
	input logic mclk,
	input logic rst,
	input cmd_type cmd,
	input logic [BANK_W-1:0] bank,
	input logic [ADDR_W-1:0] addr,
	input logic dq_ctl_oe_n,
	input logic dqs_ctl,
	input logic dqs_ctl_oe_n,
	input logic dq_dev_oe_n,
	input logic dqs_dev,
	input logic dqs_dev_oe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [19:0] hist;
	logic [19:0] next_hist;
	logic [3:0] cur_lat;
	logic [3:0] next_cur_lat;
	logic [3:0] mod_cnt;
	logic [3:0] next_mod_cnt;
	logic [3:0] wtr_cnt;
	logic [3:0] next_wtr_cnt;
	logic pre_win;
	logic data_win;
	logic rel_win;

	// Read history, tracked latency and spacing counters
	always_comb begin
		next_hist = {hist[18:0], cmd == cmd_read};
		next_cur_lat = (cmd == cmd_mode_set) ? addr[LATENCY_LSB +: 4] : cur_lat;
		next_mod_cnt = (cmd == cmd_mode_set) ? 4'd11 : ((mod_cnt != 0) ? mod_cnt - 4'd1 : 4'd0);
		next_wtr_cnt = (cmd == cmd_write) ? 4'd12 : ((wtr_cnt != 0) ? wtr_cnt - 4'd1 : 4'd0);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hist <= '0;
			cur_lat <= READ_LATENCY_RESET;
			mod_cnt <= '0;
			wtr_cnt <= '0;
		end else begin
			hist <= next_hist;
			cur_lat <= next_cur_lat;
			mod_cnt <= next_mod_cnt;
			wtr_cnt <= next_wtr_cnt;
		end
	end

	// Windows of any read in the history; an earlier burst's data overrides a later read's preamble
	always_comb begin
		pre_win = hist[cur_lat - 4'd2];
		data_win = |hist[cur_lat - 4'd1 +: 4];
		rel_win = hist[5'(cur_lat) + 5'd3];
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence wr_pre_s;
		!dqs_ctl_oe_n && !dqs_ctl && dq_ctl_oe_n;
	endsequence
	sequence wr_data_s;
		(!dq_ctl_oe_n && !dqs_ctl_oe_n && dqs_ctl)[*4];
	endsequence
	sequence wr_rel_s;
		dqs_ctl_oe_n && dq_ctl_oe_n;
	endsequence

	rd_preamble_a: assert property (pre_win && !data_win |-> !dqs_dev_oe_n && !dqs_dev)
		else $error("read preamble missing");
	rd_data_a: assert property (data_win |-> !dq_dev_oe_n && !dqs_dev_oe_n && dqs_dev)
		else $error("read data not driven at latency");
	rd_release_a: assert property (rel_win && !data_win && !pre_win |->
		dqs_dev_oe_n && dq_dev_oe_n) else $error("read strobe not released");
	mode_space_a: assert property (cmd == cmd_mode_set |=> (cmd != cmd_mode_set)[*3])
		else $error("mode sets too close");
	mode_update_a: assert property (mod_cnt != 0 |->
		cmd inside {cmd_nop, cmd_mode_set, cmd_pattern})
		else $error("command during mode update delay");
	col_space_a: assert property (cmd inside {cmd_read, cmd_write} |=>
		(!(cmd inside {cmd_read, cmd_write}))[*3]) else $error("column commands too close");
	act_space_a: assert property (cmd == cmd_activate |=> (cmd != cmd_activate)[*3])
		else $error("activates too close");
	rd_to_pre_a: assert property (cmd == cmd_read |=>
		!(cmd == cmd_precharge && bank == $past(bank, 1))
		##1 !(cmd == cmd_precharge && bank == $past(bank, 2))
		##1 !(cmd == cmd_precharge && bank == $past(bank, 3))) else $error("early precharge after read");
	wr_to_rd_a: assert property (wtr_cnt != 0 |-> cmd != cmd_read)
		else $error("read too soon after write");
	wr_strobe_a: assert property (cmd == cmd_write |-> ##4 wr_pre_s ##1 wr_data_s ##1 wr_rel_s)
		else $error("write strobe sequence wrong");
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
// Purpose: Drives the controller user side and checks spacing and read returns
// Assumes: Ready is settled shortly after a falling edge
// Notes: A request is left up after its edge; the next call replaces or lowers it
module tb;
	import ddr3_timing_pkg::*;

	localparam logic [127:0] WD = {32'h4444_dddd, 32'h3333_cccc, 32'h2222_bbbb, 32'h1111_aaaa};

	logic mclk;
	logic rst;
	logic req_valid;
	cmd_type req_cmd;
	logic [BANK_W-1:0] req_bank;
	logic [ADDR_W-1:0] req_addr;
	logic [BURST_CYCLES*DATA_W-1:0] req_wdata;
	logic req_ready;
	logic rd_valid;
	logic [DATA_W-1:0] rd_data;
	logic loop_locked;
	logic [BANKS-1:0] bank_ready;
	logic pattern_mode;
	logic [3:0] read_latency;
	int cyc;
	int t_take;
	int t_prev;
	int num_errors;
	int n_tests;
	int i;

	// ----------------------------------------
	// Both ends across the link
	// ----------------------------------------
	ddr3_link_if ddr3_link_if_inst();

	ddr3_controller_end ddr3_controller_end_inst (.mclk(mclk), .rst(rst), .link(ddr3_link_if_inst),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.loop_locked(loop_locked));

	ddr3_device_end ddr3_device_end_inst (.mclk(mclk), .rst(rst), .link(ddr3_link_if_inst),
		.bank_ready(bank_ready), .pattern_mode(pattern_mode), .read_latency(read_latency));

	ddr3_link_asserts ddr3_link_asserts_inst (.mclk(mclk), .rst(rst),
		.cmd(ddr3_link_if_inst.cmd), .bank(ddr3_link_if_inst.bank), .addr(ddr3_link_if_inst.addr),
		.dq_ctl_oe_n(ddr3_link_if_inst.dq_ctl_oe_n), .dqs_ctl(ddr3_link_if_inst.dqs_ctl),
		.dqs_ctl_oe_n(ddr3_link_if_inst.dqs_ctl_oe_n), .dq_dev_oe_n(ddr3_link_if_inst.dq_dev_oe_n),
		.dqs_dev(ddr3_link_if_inst.dqs_dev), .dqs_dev_oe_n(ddr3_link_if_inst.dqs_dev_oe_n));

	// ----------------------------------------
	// Clock, cycle count, watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Edges since reset release, used to measure command spacing
	always @(posedge mclk or posedge rst) begin
		if (rst) cyc <= 0;
		else cyc <= cyc + 1;
	end

	// Whole run is under 1200 cycles; loop lock is waited out twice
	initial begin
		#(50 * 2000);
		num_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] spacing();
		return 32'(t_take - t_prev);
	endfunction

	// Holds the request until ready, bounded since reads wait out loop lock
	task automatic issue(input cmd_type c, input logic [2:0] b, input logic [12:0] a);
		int n;
		@(negedge mclk);
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = b;
		req_addr = a;
		req_wdata = WD;
		n = 0;
		#1;
		while (req_ready !== 1'b1 && n < 700) begin
			@(negedge mclk);
			#1;
			n++;
		end
		if (n >= 700) begin
			num_errors++;
			$display("ERROR %0t: request never accepted", $time);
		end
		t_prev = t_take;
		t_take = cyc + 1;
		@(posedge mclk);
	endtask

	task automatic idle(input int n);
		@(negedge mclk);
		req_valid = 1'b0;
		repeat (n) @(negedge mclk);
	endtask

	// Gathers read words; src repeats every four words
	task automatic collect(input int n, input int first, input int last, input logic [127:0] src);
		int k;
		int f;
		int l;
		k = 0;
		f = 0;
		l = 0;
		@(negedge mclk);
		req_valid = 1'b0;
		for (int j = 0; j < 40 && k < n; j++) begin
			if (rd_valid === 1'b1) begin
				if (k == 0) f = cyc;
				l = cyc;
				check(rd_data, src[(k % 4) * 32 +: 32]);
				k++;
			end
			@(negedge mclk);
		end
		check(32'(k), 32'(n));
		check(32'(f), 32'(first));
		check(32'(l), 32'(last));
	endtask

	task automatic complete_run();
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = cmd_nop;
		req_bank = '0;
		req_addr = '0;
		req_wdata = '0;
		num_errors = 0;
		n_tests = 0;
		t_take = 0;
		t_prev = 0;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check(32'(read_latency), 32'h0000_0006);
		check(32'({pattern_mode, loop_locked, bank_ready}), 32'h0000_00ff);
		issue(cmd_mode_set, 3'd0, 13'h0056);
		issue(cmd_mode_set, 3'd0, 13'h0056);
		check(spacing(), 32'h0000_0004);
		issue(cmd_activate, 3'd0, 13'h0000);
		check(spacing(), 32'h0000_000c);
		for (i = 1; i < 5; i++) begin
			issue(cmd_activate, 3'(i), 13'h0000);
			check(spacing(), 32'h0000_0004);
		end
		issue(cmd_read, 3'd0, 13'h0000);
		check(32'(t_take >= 512 && t_take <= 514), 32'h0000_0001);
		issue(cmd_precharge, 3'd0, 13'h0000);
		check(spacing(), 32'h0000_0004);
		issue(cmd_write, 3'd1, 13'h0000);
		issue(cmd_read, 3'd1, 13'h0000);
		check(spacing(), 32'h0000_000d);
		collect(4, t_take + 7, t_take + 10, WD);
		issue(cmd_write, 3'd3, 13'h0000);
		issue(cmd_write, 3'd4, 13'h0000);
		check(spacing(), 32'h0000_000a);
		issue(cmd_precharge, 3'd4, 13'h0000);
		check(spacing(), 32'h0000_000a);
		// Latency 8 with the pattern register switched in
		issue(cmd_mode_set, 3'd0, 13'h0058);
		issue(cmd_pattern, 3'd0, 13'h0004);
		issue(cmd_read, 3'd1, 13'h0000);
		check(spacing(), 32'h0000_0001);
		collect(4, t_take + 9, t_take + 12, {4{MULTI_PURPOSE_REGISTER_PATTERN}});
		check(32'({pattern_mode, read_latency}), 32'h0000_0018);
		issue(cmd_pattern, 3'd0, 13'h0000);
		issue(cmd_read, 3'd1, 13'h0000);
		issue(cmd_read, 3'd1, 13'h0000);
		check(spacing(), 32'h0000_0004);
		collect(8, t_prev + 9, t_take + 12, WD);
		// Auto-precharge write locks its bank out of activates
		issue(cmd_write, 3'd2, 13'h0400);
		idle(3);
		check(32'(bank_ready), 32'h0000_00fb);
		issue(cmd_activate, 3'd2, 13'h0000);
		check(32'(spacing() >= 15 && spacing() <= 17), 32'h0000_0001);
		idle(2);
		check(32'(bank_ready), 32'h0000_00ff);
		// Loop reset through a mode set holds reads off for the whole lock time
		issue(cmd_mode_set, 3'd0, 13'h0156);
		idle(1);
		check(32'(loop_locked), 32'h0000_0000);
		issue(cmd_read, 3'd1, 13'h0000);
		check(spacing(), 32'h0000_0200);
		check(32'(loop_locked), 32'h0000_0001);
		complete_run();
	end
endmodule
